// *** common/gain_switch_pkg.sv ***
// shared constants, types and register map of the gain-set switching block
package gain_switch_pkg;

  localparam int GAIN_W    = 16;
  localparam int NUM_GAINS = 7;
  localparam int TIME_W    = 16;
  localparam int CMD_W     = 16;
  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 32;
  localparam int DIGIT_W   = 4;

  typedef logic [GAIN_W-1:0]                 gain_t;
  typedef logic [TIME_W-1:0]                 ms_time_t;
  typedef logic [NUM_GAINS-1:0][GAIN_W-1:0]  gain_vec_t;

  // first field sits in the top lane, so friction gain is lane 0
  typedef struct packed {
    gain_t speed_loop_gain;
    gain_t speed_integral_time;
    gain_t position_loop_gain;
    gain_t torque_filter_time;
    gain_t model_follow_gain;
    gain_t model_follow_correction;
    gain_t friction_comp_gain;
  } gain_set_t;

  localparam int IDX_MF_GAIN = 2;
  localparam int IDX_MF_CORR = 1;

  localparam gain_set_t GAIN_DEFAULT = '{
    speed_loop_gain:         16'h0190,
    speed_integral_time:     16'h07d0,
    position_loop_gain:      16'h0190,
    torque_filter_time:      16'h0064,
    model_follow_gain:       16'h01f4,
    model_follow_correction: 16'h03e8,
    friction_comp_gain:      16'h0064
  };

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_SELECT   = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_SW_TIME1 = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_SW_TIME2 = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_WAIT1    = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_WAIT2    = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_LOOP     = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_SET1     = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_SET2     = 12'h040;
  localparam int                WORD_LSB     = 2;
  localparam int                SET_SPAN_LSB = 5;

  // select register digits
  localparam int                 MODE_LSB    = 0;
  localparam int                 COND_LSB    = 4;
  localparam logic [DIGIT_W-1:0] MODE_MANUAL = 4'h0;
  localparam logic [DIGIT_W-1:0] MODE_AUTO_1 = 4'h2;
  localparam logic [DIGIT_W-1:0] COND_POSITIONING_COMPLETE_ON   = 4'h0;
  localparam logic [DIGIT_W-1:0] COND_POSITIONING_COMPLETE_OFF  = 4'h1;
  localparam logic [DIGIT_W-1:0] COND_NEAR_ON   = 4'h2;
  localparam logic [DIGIT_W-1:0] COND_NEAR_OFF  = 4'h3;
  localparam logic [DIGIT_W-1:0] COND_REF_IDLE  = 4'h4;
  localparam logic [DIGIT_W-1:0] COND_REF_INPUT = 4'h5;

  localparam logic [GAIN_W-1:0] SELECT_RESET = 16'h0000;
  localparam logic [TIME_W-1:0] TIME_RESET   = 16'h0000;
  localparam logic [GAIN_W-1:0] LOOP_RESET   = 16'h0000;

  // gain-set-select bit inside the servo command bits
  localparam int GSEL_BIT = 4;

  // status register bits
  localparam int ST_ACTIVE = 0;
  localparam int ST_WAIT   = 1;
  localparam int ST_RAMP   = 2;

  // millisecond timebase
  localparam int unsigned TICK_NS        = 1000000;
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned MS_TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {SW_IDLE, SW_WAIT, SW_RAMP} sw_state_t;

endpackage : gain_switch_pkg

// *** rtl/gain_ramp.sv ***
// linear interpolation of all gains between the old and the new set
module gain_ramp (
  // clock and reset
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      ce_i,
  // ramp endpoints and progress
  input  wire gain_switch_pkg::gain_vec_t from_i,
  input  wire gain_switch_pkg::gain_vec_t to_i,
  input  wire gain_switch_pkg::ms_time_t  elapsed_i,
  input  wire gain_switch_pkg::ms_time_t  total_i,
  // registered result
  output gain_switch_pkg::gain_vec_t      value_o
);
  import gain_switch_pkg::*;

  // signed product keeps downward ramps exact; division truncates toward zero
  function automatic gain_t lerp(input gain_t a, input gain_t b,
                                 input ms_time_t t, input ms_time_t n);
    logic signed [GAIN_W+1:0]        d;
    logic signed [GAIN_W+TIME_W+2:0] p;
    logic signed [GAIN_W+TIME_W+2:0] q;
    d = '0;
    p = '0;
    q = '0;
    if (n == '0 || t >= n) begin
      return b;
    end
    d = $signed({2'b00, b}) - $signed({2'b00, a});
    p = d * $signed({1'b0, t});
    q = p / $signed({1'b0, n});
    return a + q[GAIN_W-1:0];
  endfunction : lerp

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      value_o <= gain_vec_t'(GAIN_DEFAULT);
    end else if (ce_i) begin
      for (int i = 0; i < NUM_GAINS; i++) begin
        value_o[i] <= lerp(from_i[i], to_i[i], elapsed_i, total_i);
      end
    end
  end

endmodule : gain_ramp

// *** rtl/gain_switch.sv ***
// gain-set switching: manual or automatic selection with wait and linear ramp
// Operation
// - lowest select digit picks manual or automatic
// - two seven-value gain sets held
// - model-following values switch only in manual mode
// - model-following change needs stopped, no reference
// - manual mode follows gain-set-select bit
// - automatic switching only under position control
// - second digit encodes switching condition A
// - outside position control, fixed set by code
// - condition met: set 1 to set 2
// - condition lost: set 2 to set 1
// - transition starts after waiting time
// - gains ramp linearly over switching time
// - works with either speed loop structure
// - times 0 to 65535 ms, zero immediate
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
module gain_switch #(
  parameter int unsigned TICK_CYCLES = gain_switch_pkg::MS_TICK_CYCLES
) (
  // clock, reset, enable
  input  wire logic                                     core_clk_i,
  input  wire logic                                     rst_i,
  input  wire logic                                     ce_i,
  // apb slave
  input  wire logic                                     psel_i,
  input  wire logic                                     penable_i,
  input  wire logic                                     pwrite_i,
  input  wire logic [gain_switch_pkg::ADDR_W-1:0]       paddr_i,
  input  wire logic [gain_switch_pkg::DATA_W-1:0]       pwdata_i,
  output logic      [gain_switch_pkg::DATA_W-1:0]       prdata_o,
  output logic                                          pready_o,
  output logic                                          pslverr_o,
  // host command and control-loop status
  input  wire logic [gain_switch_pkg::CMD_W-1:0]        servo_command_bits_i,
  input  wire logic                                     positioning_complete_i,
  input  wire logic                                     near_position_i,
  input  wire logic                                     ref_filter_zero_i,
  input  wire logic                                     ref_input_on_i,
  input  wire logic                                     motor_stopped_i,
  input  wire logic                                     position_control_i,
  // gains to the control loops
  output gain_switch_pkg::gain_set_t                    gains_o,
  output logic                                          active_set_o,
  output logic                                          ramping_o
);
  import gain_switch_pkg::*;

  logic [GAIN_W-1:0]  sel_q;
  logic [GAIN_W-1:0]  loop_struct_q;
  ms_time_t           sw_first_q;
  ms_time_t           sw_second_q;
  ms_time_t           wait_first_q;
  ms_time_t           wait_second_q;
  gain_vec_t          set1_q;
  gain_vec_t          set2_q;
  logic [31:0]        tick_cnt_q;
  logic               tick_q;
  sw_state_t          state_q;
  logic               target_q;
  gain_vec_t          from_q;
  logic               mf_freeze_q;
  ms_time_t           wait_cnt_q;
  ms_time_t           elapsed_q;
  ms_time_t           total_q;
  gain_vec_t          to_vec;
  gain_vec_t          gains_vec;
  logic [DIGIT_W-1:0] mode;
  logic [DIGIT_W-1:0] cond;
  logic               cond_a;
  logic               want_set;
  logic               immediate;
  logic               mf_allow;
  logic               start;
  ms_time_t           start_wait;
  ms_time_t           start_total;
  logic               wr_en;
  logic [DATA_W-1:0]  rd_data;
  logic               rd_err;

  // address of a gain register within one set, or no hit
  function automatic logic set_hit(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] base);
    return (a[ADDR_W-1:SET_SPAN_LSB] == base[ADDR_W-1:SET_SPAN_LSB]) &&
           (a[SET_SPAN_LSB-1:WORD_LSB] < 3'(NUM_GAINS)) && (a[WORD_LSB-1:0] == 2'h0);
  endfunction : set_hit

  // lane index in gain_vec_t: offset 0 is the speed loop gain (top lane)
  function automatic int set_lane(input logic [ADDR_W-1:0] a);
    return NUM_GAINS - 1 - int'(a[SET_SPAN_LSB-1:WORD_LSB]);
  endfunction : set_lane

  // condition A from the second select digit
  function automatic logic cond_a_met(input logic [DIGIT_W-1:0] c);
    case (c)
      COND_POSITIONING_COMPLETE_ON:   return positioning_complete_i;
      COND_POSITIONING_COMPLETE_OFF:  return !positioning_complete_i;
      COND_NEAR_ON:   return near_position_i;
      COND_NEAR_OFF:  return !near_position_i;
      COND_REF_IDLE:  return ref_filter_zero_i && !ref_input_on_i;
      COND_REF_INPUT: return ref_input_on_i;
      default:        return 1'b0;
    endcase
  endfunction : cond_a_met

  assign mode   = sel_q[MODE_LSB +: DIGIT_W];
  assign cond   = sel_q[COND_LSB +: DIGIT_W];
  assign cond_a = cond_a_met(cond);

  // apb: one wait-free access cycle, pready raised from the setup phase
  assign wr_en = psel_i && penable_i && pwrite_i && pready_o;

  always_comb begin
    rd_data = '0;
    rd_err  = 1'b0;
    if (set_hit(paddr_i, OFS_SET1)) begin
      rd_data = DATA_W'(set1_q[set_lane(paddr_i)]);
    end else if (set_hit(paddr_i, OFS_SET2)) begin
      rd_data = DATA_W'(set2_q[set_lane(paddr_i)]);
    end else begin
      case (paddr_i)
        OFS_SELECT:   rd_data = DATA_W'(sel_q);
        OFS_SW_TIME1: rd_data = DATA_W'(sw_first_q);
        OFS_SW_TIME2: rd_data = DATA_W'(sw_second_q);
        OFS_WAIT1:    rd_data = DATA_W'(wait_first_q);
        OFS_WAIT2:    rd_data = DATA_W'(wait_second_q);
        OFS_LOOP:     rd_data = DATA_W'(loop_struct_q);
        OFS_STATUS: begin
          rd_data[ST_ACTIVE] = target_q;
          rd_data[ST_WAIT]   = (state_q == SW_WAIT);
          rd_data[ST_RAMP]   = (state_q == SW_RAMP);
        end
        default:      rd_err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= '0;
      pslverr_o <= 1'b0;
    end else if (ce_i) begin
      pready_o  <= psel_i && !penable_i;
      prdata_o  <= (psel_i && !penable_i && !pwrite_i) ? rd_data : '0;
      pslverr_o <= psel_i && !penable_i && rd_err;
    end
  end

  // parameter registers; loop structure is stored only, switching never looks at it
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_q         <= SELECT_RESET;
      loop_struct_q <= LOOP_RESET;
      sw_first_q    <= TIME_RESET;
      sw_second_q   <= TIME_RESET;
      wait_first_q  <= TIME_RESET;
      wait_second_q <= TIME_RESET;
      set1_q        <= gain_vec_t'(GAIN_DEFAULT);
      set2_q        <= gain_vec_t'(GAIN_DEFAULT);
    end else if (ce_i && wr_en) begin
      if (set_hit(paddr_i, OFS_SET1)) begin
        set1_q[set_lane(paddr_i)] <= pwdata_i[GAIN_W-1:0];
      end else if (set_hit(paddr_i, OFS_SET2)) begin
        set2_q[set_lane(paddr_i)] <= pwdata_i[GAIN_W-1:0];
      end else begin
        case (paddr_i)
          OFS_SELECT:   sel_q         <= pwdata_i[GAIN_W-1:0];
          OFS_SW_TIME1: sw_first_q    <= pwdata_i[TIME_W-1:0];
          OFS_SW_TIME2: sw_second_q   <= pwdata_i[TIME_W-1:0];
          OFS_WAIT1:    wait_first_q  <= pwdata_i[TIME_W-1:0];
          OFS_WAIT2:    wait_second_q <= pwdata_i[TIME_W-1:0];
          OFS_LOOP:     loop_struct_q <= pwdata_i[GAIN_W-1:0];
          default:      ;
        endcase
      end
    end
  end

  // millisecond tick
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (ce_i) begin
      if (tick_cnt_q >= 32'(TICK_CYCLES - 1)) begin
        tick_cnt_q <= '0;
        tick_q     <= 1'b1;
      end else begin
        tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
        tick_q     <= 1'b0;
      end
    end
  end

  // wanted set and whether the change is timed
  always_comb begin
    want_set  = target_q;
    immediate = 1'b1;
    case (mode)
      MODE_MANUAL: want_set = servo_command_bits_i[GSEL_BIT];
      MODE_AUTO_1: begin
        if (position_control_i) begin
          want_set  = cond_a;
          immediate = 1'b0;
        end else begin
          want_set  = cond[0];
        end
      end
      default:     want_set = target_q;
    endcase
  end

  // model-following values move only on a manual change at standstill
  assign mf_allow    = (mode == MODE_MANUAL) && motor_stopped_i && !ref_input_on_i;
  assign start       = tick_q && (want_set != target_q);
  assign start_wait  = immediate ? '0 : (want_set ? wait_first_q : wait_second_q);
  assign start_total = immediate ? '0 : (want_set ? sw_first_q : sw_second_q);

  // sequencer: idle, wait, ramp; a reversal at any point restarts from the present gains
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q     <= SW_IDLE;
      target_q    <= 1'b0;
      from_q      <= gain_vec_t'(GAIN_DEFAULT);
      mf_freeze_q <= 1'b0;
      wait_cnt_q  <= '0;
      elapsed_q   <= '0;
      total_q     <= '0;
    end else if (ce_i && start) begin
      target_q    <= want_set;
      from_q      <= gains_vec;
      mf_freeze_q <= !mf_allow;
      wait_cnt_q  <= start_wait;
      elapsed_q   <= '0;
      total_q     <= start_total;
      state_q     <= (start_wait == '0) ? SW_RAMP : SW_WAIT;
    end else if (ce_i && tick_q) begin
      case (state_q)
        SW_WAIT: begin
          if (wait_cnt_q <= 16'h0001) begin
            state_q <= SW_RAMP;
          end
          wait_cnt_q <= wait_cnt_q - 16'h0001;
        end
        SW_RAMP: begin
          if (elapsed_q + 16'h0001 >= total_q) begin
            elapsed_q <= total_q;
            state_q   <= SW_IDLE;
          end else begin
            elapsed_q <= elapsed_q + 16'h0001;
          end
        end
        default: state_q <= SW_IDLE;
      endcase
    end
  end

  always_comb begin
    to_vec = (state_q == SW_WAIT) ? from_q : (target_q ? set2_q : set1_q);
    if (mf_freeze_q) begin
      to_vec[IDX_MF_GAIN] = from_q[IDX_MF_GAIN];
      to_vec[IDX_MF_CORR] = from_q[IDX_MF_CORR];
    end
  end

  gain_ramp u_ramp (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .from_i     (from_q),
    .to_i       (to_vec),
    .elapsed_i  (elapsed_q),
    .total_i    (total_q),
    .value_o    (gains_vec)
  );

  assign gains_o = gain_set_t'(gains_vec);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      active_set_o <= 1'b0;
      ramping_o    <= 1'b0;
    end else if (ce_i) begin
      active_set_o <= target_q;
      ramping_o    <= (state_q != SW_IDLE);
    end
  end

  a_manual_gsel: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && tick_q && mode == MODE_MANUAL && servo_command_bits_i[GSEL_BIT] != target_q
    |=> target_q == $past(servo_command_bits_i[GSEL_BIT]) && total_q == '0)
    else $error("manual select not followed");

  a_reserved_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    mode != MODE_MANUAL && mode != MODE_AUTO_1 |=> $stable(target_q))
    else $error("set changed under reserved mode");

  a_fixed_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && tick_q && mode == MODE_AUTO_1 && !position_control_i
    |=> target_q == $past(cond[0]) ##1 active_set_o == $past(cond[0], 2))
    else $error("fixed set not applied outside position control");

  a_no_timed_switch: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && start && mode == MODE_AUTO_1 && !position_control_i
    |=> total_q == '0 && state_q == SW_RAMP)
    else $error("timed switch outside position control");

  a_cond_to_set2: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && tick_q && mode == MODE_AUTO_1 && position_control_i && cond_a && !target_q
    |=> target_q && total_q == $past(sw_first_q) && wait_cnt_q == $past(wait_first_q))
    else $error("set 2 transition timing wrong");

  a_back_to_set1: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && tick_q && mode == MODE_AUTO_1 && position_control_i && !cond_a && target_q
    |=> !target_q && total_q == $past(sw_second_q) && wait_cnt_q == $past(wait_second_q))
    else $error("set 1 transition timing wrong");

  a_wait_holds: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && tick_q && state_q == SW_WAIT && wait_cnt_q > 16'h0001 && !start
    |=> state_q == SW_WAIT && gains_vec == $past(from_q))
    else $error("ramp began before waiting time");

  a_ramp_end: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && state_q == SW_IDLE |=> gains_vec == $past(to_vec))
    else $error("idle gains differ from target set");

  a_mf_auto: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && start && mode == MODE_AUTO_1 |=> mf_freeze_q)
    else $error("model-following switched in automatic mode");

  a_mf_frozen: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && mf_freeze_q |=> gains_vec[IDX_MF_GAIN] == $past(from_q[IDX_MF_GAIN]))
    else $error("frozen model-following gain moved");

  a_reverse_from_now: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && start && state_q != SW_IDLE |=> from_q == $past(gains_vec))
    else $error("reversal did not restart from present gains");

  a_tick_single: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && tick_q |=> !tick_q)
    else $error("tick longer than one cycle");

endmodule : gain_switch

// *** dv/host_cmd_model.sv ***
// host controller model: flips the gain-set-select bit only while the motor stands
module host_cmd_model #(
  parameter int unsigned TICK_CYCLES = 4
) (
  // clock and reset
  input  wire logic                              core_clk_i,
  input  wire logic                              rst_i,
  // request from the bench and motor state
  input  wire logic                              want_set2_i,
  input  wire logic                              motor_stopped_i,
  // command bits and settle flag
  output logic [gain_switch_pkg::CMD_W-1:0]      servo_command_bits_o,
  output logic                                   settled_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import gain_switch_pkg::*;
  int unsigned hold_q;

  // a request made while moving is simply held back until the motor stops
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      servo_command_bits_o <= '0;
      hold_q               <= 0;
    end else if (motor_stopped_i && servo_command_bits_o[GSEL_BIT] != want_set2_i) begin
      servo_command_bits_o[GSEL_BIT] <= want_set2_i;
      hold_q                         <= 2 * TICK_CYCLES;
    end else if (hold_q != 0) begin
      hold_q <= hold_q - 1;
    end
  end

  assign settled_o = (hold_q == 0) && (servo_command_bits_o[GSEL_BIT] == want_set2_i);
endmodule : host_cmd_model

// *** dv/servo_gain_set_switching_bench.sv ***
// self-checking bench for the gain-set switching block
module servo_gain_set_switching_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import gain_switch_pkg::*;
  localparam int TK = 4;
  logic              clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, want = 0, stop = 1;
  logic              positioning_complete = 0, nearp = 0, rfz = 0, refon = 0, posc = 0, ce = 1;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata, rd;
  logic              pready, pslverr, act, ramp, settled, er;
  logic [CMD_W-1:0]  cmd;
  gain_set_t         gains;
  gain_t             s1[7], s2[7];
  logic [31:0]       lf = 32'hab4dd4a3;
  int                failures = 0, check_count = 0, cyc = 0;

  always #2.5 clk = ~clk;

  gain_switch #(.TICK_CYCLES(TK)) i_dut (
    .core_clk_i(clk), .rst_i(rst), .ce_i(ce), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .servo_command_bits_i(cmd),
    .positioning_complete_i(positioning_complete), .near_position_i(nearp), .ref_filter_zero_i(rfz),
    .ref_input_on_i(refon), .motor_stopped_i(stop), .position_control_i(posc),
    .gains_o(gains), .active_set_o(act), .ramping_o(ramp));

  host_cmd_model #(.TICK_CYCLES(TK)) i_host (
    .core_clk_i(clk), .rst_i(rst), .want_set2_i(want), .motor_stopped_i(stop),
    .servo_command_bits_o(cmd), .settled_o(settled));

  task automatic stop_test();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end

  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction : nxt

  // model: plain lanes follow the target set, model-following lanes their own set
  function automatic gain_vec_t expv(input int t, input int m);
    gain_vec_t v;
    for (int k = 0; k < 7; k++)
      v[6-k] = (((k == 4 || k == 5) ? m : t) == 2) ? s2[k] : s1[k];
    return v;
  endfunction : expv

  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    psel   <= 1;
    pen    <= 0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    pen  <= 0;
  endtask : apb

  task automatic rdchk(input logic [ADDR_W-1:0] a, input gain_t e);
    apb(1'b0, a, '0);
    chk({er, rd}, {1'b0, 16'h0, e});
  endtask : rdchk

  task automatic settle();
    repeat (3 * TK + 4) @(posedge clk);
  endtask : settle

  // drive the inputs so that condition c is met or not
  task automatic cond(input int c, input logic sat);
    positioning_complete  <= (c == 0) ? sat : (c == 1) ? !sat : 1'b0;
    nearp <= (c == 2) ? sat : (c == 3) ? !sat : 1'b0;
    rfz   <= (c == 4) ? sat : 1'b0;
    refon <= (c == 5) ? sat : 1'b0;
    settle();
  endtask : cond

  // follow one transition, the speed loop gain must stay between lo and hi every cycle
  task automatic run_ramp(input gain_t lo, input gain_t hi, output int n);
    int w = 0;
    n = 0;
    while (ramp !== 1'b1 && w < 3 * TK) begin
      @(posedge clk);
      w++;
    end
    while (ramp === 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
      chk(gains.speed_loop_gain >= lo && gains.speed_loop_gain <= hi, 1'b1);
    end
  endtask : run_ramp

  initial begin
    gain_vec_t dv;
    int        n;
    dv = gain_vec_t'(GAIN_DEFAULT);
    for (int k = 0; k < 7; k++) begin
      s1[k] = dv[6-k];
      s2[k] = dv[6-k];
    end
    repeat (16) @(posedge clk);
    rst <= 0;
    chk(gains, expv(1, 1));
    rdchk(OFS_SELECT, SELECT_RESET);
    for (int k = 0; k < 4; k++)
      rdchk(ADDR_W'(OFS_SW_TIME1 + 4 * k), TIME_RESET);
    for (int k = 0; k < 7; k++) begin
      rdchk(ADDR_W'(OFS_SET1 + 4 * k), s1[k]);
      rdchk(ADDR_W'(OFS_SET2 + 4 * k), s2[k]);
      lf = nxt(lf);
      s2[k] = lf[15:0];
      apb(1'b1, ADDR_W'(OFS_SET2 + 4 * k), lf);
      rdchk(ADDR_W'(OFS_SET2 + 4 * k), s2[k]);
    end
    apb(1'b1, 12'h100, 32'h5a5a);
    chk({er, rd}, {1'b1, 32'h0});
    // manual: first step has a reference present, so model-following must not move
    for (int i = 0; i < 4; i++) begin
      want  <= (i % 2 == 0);
      refon <= (i == 0);
      settle();
      chk(gains, expv((i % 2 == 0) ? 2 : 1, (i == 0) ? 1 : ((i % 2 == 0) ? 2 : 1)));
      chk(act, i % 2 == 0);
    end
    refon <= 0;
    // select flipped just before the motor moves off: model-following lanes stay
    want <= 1;
    @(posedge clk);
    stop <= 0;
    settle();
    chk(gains, expv(2, 1));
    // while moving the host holds its request back
    want <= 0;
    settle();
    chk({act, settled}, 2'b10);
    stop <= 1;
    settle();
    chk({act, settled}, 2'b01);
    chk(gains, expv(1, 1));
    // enable low freezes the tick, so the select waits
    ce   <= 0;
    want <= 1;
    settle();
    chk({act, ramp}, 2'b00);
    ce <= 1;
    settle();
    chk(act, 1'b1);
    want <= 0;
    settle();
    apb(1'b1, OFS_LOOP, 32'h1);
    rdchk(OFS_LOOP, 16'h1);
    apb(1'b1, OFS_WAIT1, 32'h2);
    apb(1'b1, OFS_SW_TIME1, 32'h4);
    apb(1'b1, OFS_WAIT2, 32'ha);
    apb(1'b1, OFS_SELECT, 32'h2);
    posc <= 1;
    settle();
    chk(gains, expv(1, 1));
    positioning_complete <= 1;
    run_ramp(s1[0] < s2[0] ? s1[0] : s2[0], s1[0] < s2[0] ? s2[0] : s1[0], n);
    chk(n >= 5 * TK && n <= 7 * TK, 1'b1);
    chk(gains, expv(2, 1));
    chk(act, 1'b1);
    rdchk(OFS_STATUS, gain_t'(1 << ST_ACTIVE));
    // condition drops and returns inside the long wait: gains never leave set 2
    positioning_complete <= 0;
    repeat (3 * TK) @(posedge clk);
    positioning_complete <= 1;
    run_ramp(s2[0], s2[0], n);
    chk(gains, expv(2, 1));
    positioning_complete <= 0;
    run_ramp(s1[0] < s2[0] ? s1[0] : s2[0], s1[0] < s2[0] ? s2[0] : s1[0], n);
    chk(n >= 9 * TK && n <= 12 * TK, 1'b1);
    chk(gains, expv(1, 1));
    apb(1'b1, OFS_WAIT1, 32'h0);
    apb(1'b1, OFS_SW_TIME1, 32'h0);
    apb(1'b1, OFS_WAIT2, 32'h0);
    for (int c = 0; c < 6; c++) begin
      apb(1'b1, OFS_SELECT, DATA_W'(c * 16 + 2));
      posc <= 1;
      cond(c, 1'b0);
      chk(act, 1'b0);
      cond(c, 1'b1);
      chk(act, 1'b1);
      posc <= 0;
      cond(c, 1'b0);
      chk(act, c[0]);
    end
    // reserved mode holds the set even though the select bit asks for set 1
    apb(1'b1, OFS_SELECT, 32'h1);
    settle();
    chk(act, 1'b1);
    apb(1'b1, OFS_SELECT, 32'h0);
    settle();
    chk(act, 1'b0);
    stop_test();
  end
endmodule : servo_gain_set_switching_bench
